/* src/dts_transition.sv */
// Purpose: transition signals and init-pending flags of one data path
// Assumes: path state and module-ready state come from outside
// Notes: control bits live in registers on the plain register port
// Operation
// R1: teardown is not-ready or low power or deinit term
// R2: deinit term ORs deinit request bits of the path's host lanes
// R3: stepped flag 0: reteardown is teardown OR reinit term
// R4: reinit term ORs init-pending flags of the path's host lanes
// R5: successful apply-with-init copy sets all triggered lanes' pending flags
// R6: immediate apply leaves the pending flags unchanged
// R7: pending flags of the path clear while path is initialising
// R8: stepped flag 1: reteardown equals teardown alone
// R9: deactivate is reteardown or tx disable or force squelch term
// R10: tx disable and squelch terms OR media lane bits of the path
// R11: any lane disabled or squelched forces whole path toward turn-off
// R12: host loads active set, then writes deinit bits 0 or 1
// R13: signals use only this path's lanes, recomputed every cycle
`timescale 1ns/1ps
`include "dts_defs.svh"

module dts_transition #(
    parameter int LANES = `DTS_LANES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [`DTS_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic module_ready_state,
    input wire logic low_power_signal,
    input wire dts_pkg::dts_path_state_t path_state,
    input wire logic copy_done,
    output logic path_teardown_signal,
    output logic path_reteardown_signal,
    output logic path_deactivate_signal
);
    import dts_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [LANES-1:0] lane_deinit_request_bit_r;
    logic [LANES-1:0] lane_tx_output_disable_bit_r;
    logic [LANES-1:0] lane_tx_squelch_force_bit_r;
    logic [LANES-1:0] lane_init_pending_flag_r;
    logic [LANES-1:0] apply_lanes_r;
    logic apply_wait_r;
    logic stepped_only_config_flag_r;
    logic [3:0] first_lane_r;
    logic [3:0] lane_count_r;
    logic [31:0] cfg_r;
    logic [31:0] reg_rdata_r;
    logic [LANES-1:0] host_mask;
    logic [LANES-1:0] media_mask;
    logic path_deinit_term;
    logic path_reinit_term;
    logic path_tx_disable_term;
    logic path_tx_force_squelch_term;
    logic apply_init_wr;
    logic [LANES-1:0] wr_lanes;
    logic [LANES-1:0] pending_set_lanes;
    logic [LANES-1:0] clear_lanes;

    // lanes n .. n+m-1 of this path
    function automatic logic [LANES-1:0] lane_mask(
        input logic [3:0] first,
        input logic [3:0] count
    );
        logic [LANES-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            if (i >= int'(first) && i < int'(first) + int'(count)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    assign host_mask = lane_mask(first_lane_r, lane_count_r); // [R13]
    assign media_mask = host_mask;
    assign apply_init_wr = reg_wr && reg_addr == `DTS_OFF_APPLY
        && reg_wdata[`DTS_APPLY_INIT_BIT];
    assign wr_lanes = reg_wdata[LANES-1:0];

    // ----------------------------------------
    // host control writes
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            lane_deinit_request_bit_r <= LANES'(`DTS_DEINIT_RST);
            lane_tx_output_disable_bit_r <= '0;
            lane_tx_squelch_force_bit_r <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                `DTS_OFF_DEINIT: lane_deinit_request_bit_r <=
                    reg_wdata[LANES-1:0]; // [R12]
                `DTS_OFF_TXDIS: lane_tx_output_disable_bit_r <=
                    reg_wdata[LANES-1:0];
                `DTS_OFF_SQF: lane_tx_squelch_force_bit_r <=
                    reg_wdata[LANES-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_r <= `DTS_CFG_RST;
        end else if (reg_wr && reg_addr == `DTS_OFF_CFG) begin
            cfg_r <= reg_wdata;
        end
    end

    assign stepped_only_config_flag_r = cfg_r[`DTS_CFG_STEPPED_BIT];
    assign first_lane_r = cfg_r[`DTS_CFG_FIRST_LSB +: 4];
    assign lane_count_r = cfg_r[`DTS_CFG_COUNT_LSB +: 4];

    // ----------------------------------------
    // apply triggers and pending flags
    // ----------------------------------------
    // apply-with-init waits for the staged copy to complete
    always_ff @(posedge clock) begin
        if (rst) begin
            apply_wait_r <= 1'b0;
            apply_lanes_r <= '0;
        end else if (apply_init_wr) begin
            apply_wait_r <= 1'b1;
            apply_lanes_r <= reg_wdata[LANES-1:0];
        end else if (copy_done) begin
            apply_wait_r <= 1'b0;
        end
    end

    // immediate trigger has no path here at all [R6]
    // a copy landing during init keeps its lanes: set beats clear
    assign pending_set_lanes = (apply_wait_r && copy_done) ?
        apply_lanes_r : '0; // [R5]
    assign clear_lanes = (path_state == DTS_INITIALISING) ?
        host_mask : '0; // [R7]

    always_ff @(posedge clock) begin
        if (rst) begin
            lane_init_pending_flag_r <= '0;
        end else begin
            lane_init_pending_flag_r <= (lane_init_pending_flag_r
                & ~clear_lanes) | pending_set_lanes; // [R5] [R7]
        end
    end

    // ----------------------------------------
    // transition signals
    // ----------------------------------------
    assign path_deinit_term =
        |(lane_deinit_request_bit_r & host_mask); // [R2]
    assign path_reinit_term =
        |(lane_init_pending_flag_r & host_mask); // [R4]
    assign path_tx_disable_term =
        |(lane_tx_output_disable_bit_r & media_mask); // [R10]
    assign path_tx_force_squelch_term =
        |(lane_tx_squelch_force_bit_r & media_mask); // [R10]

    always_comb begin
        path_teardown_signal = !module_ready_state || low_power_signal
            || path_deinit_term; // [R1]
        if (stepped_only_config_flag_r) begin
            path_reteardown_signal = path_teardown_signal; // [R8]
        end else begin
            path_reteardown_signal = path_teardown_signal
                || path_reinit_term; // [R3]
        end
        // one lane off deactivates the whole path [R11]
        path_deactivate_signal = path_reteardown_signal
            || path_tx_disable_term || path_tx_force_squelch_term; // [R9]
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata_r <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `DTS_OFF_DEINIT: reg_rdata_r <=
                    32'(lane_deinit_request_bit_r);
                `DTS_OFF_TXDIS: reg_rdata_r <=
                    32'(lane_tx_output_disable_bit_r);
                `DTS_OFF_SQF: reg_rdata_r <=
                    32'(lane_tx_squelch_force_bit_r);
                `DTS_OFF_CFG: reg_rdata_r <= cfg_r;
                `DTS_OFF_PEND: reg_rdata_r <=
                    32'(lane_init_pending_flag_r);
                `DTS_OFF_SIG: reg_rdata_r <= {29'h0,
                    path_deactivate_signal, path_reteardown_signal,
                    path_teardown_signal};
                `DTS_OFF_STATE: reg_rdata_r <= 32'(path_state);
                default: reg_rdata_r <= '0;
            endcase
        end else begin
            reg_rdata_r <= '0;
        end
    end

    assign reg_rdata = reg_rdata_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    teardown_eq_a: assert property (@(posedge clock) // [R1]
        disable iff (rst) path_teardown_signal == (!module_ready_state
        || low_power_signal || path_deinit_term))
        else $error("teardown mismatch");
    teardown_cause_a: assert property (@(posedge clock) // [R1]
        disable iff (rst) !module_ready_state || low_power_signal
        |-> path_teardown_signal)
        else $error("teardown missed");
    deinit_term_a: assert property (@(posedge clock) // [R2]
        disable iff (rst)
        path_deinit_term == |(lane_deinit_request_bit_r & host_mask))
        else $error("deinit term mismatch");
    reteardown_free_a: assert property (@(posedge clock) // [R3]
        disable iff (rst) !stepped_only_config_flag_r |->
        path_reteardown_signal == (path_teardown_signal || path_reinit_term))
        else $error("reteardown mismatch");
    reinit_term_a: assert property (@(posedge clock) // [R4]
        disable iff (rst)
        path_reinit_term == |(lane_init_pending_flag_r & host_mask))
        else $error("reinit term mismatch");
    pend_read_a: assert property (@(posedge clock) // [R4]
        disable iff (rst) reg_rd && reg_addr == `DTS_OFF_PEND
        |=> reg_rdata == 32'($past(lane_init_pending_flag_r)))
        else $error("pending read mismatch");
    pending_set_a: assert property (@(posedge clock) // [R5]
        disable iff (rst) apply_wait_r && copy_done
        |=> (lane_init_pending_flag_r & $past(apply_lanes_r))
        == $past(apply_lanes_r)) else $error("pending not set");
    pending_rise_a: assert property (@(posedge clock) // [R5]
        disable iff (rst) 1'b1 |=> (lane_init_pending_flag_r
        & ~$past(lane_init_pending_flag_r) & ~$past(pending_set_lanes))
        == '0) else $error("pending set unarmed");
    arm_lanes_a: assert property (@(posedge clock) // [R5]
        disable iff (rst) apply_init_wr |=> apply_wait_r
        && apply_lanes_r == $past(wr_lanes))
        else $error("apply lanes not armed");
    pending_hold_a: assert property (@(posedge clock) // [R6]
        disable iff (rst) !(apply_wait_r && copy_done)
        && path_state != DTS_INITIALISING
        |=> $stable(lane_init_pending_flag_r))
        else $error("pending changed");
    immediate_arm_a: assert property (@(posedge clock) // [R6]
        disable iff (rst) !apply_wait_r && !apply_init_wr
        |=> !apply_wait_r) else $error("armed without trigger");
    pending_clear_a: assert property (@(posedge clock) // [R7]
        disable iff (rst) path_state == DTS_INITIALISING
        |=> (lane_init_pending_flag_r & $past(host_mask)
        & ~$past(pending_set_lanes)) == '0)
        else $error("pending not cleared");
    state_read_a: assert property (@(posedge clock) // [R7]
        disable iff (rst) reg_rd && reg_addr == `DTS_OFF_STATE
        |=> reg_rdata == 32'($past(path_state)))
        else $error("state read mismatch");
    reteardown_step_a: assert property (@(posedge clock) // [R8]
        disable iff (rst) stepped_only_config_flag_r
        |-> path_reteardown_signal == path_teardown_signal)
        else $error("stepped reteardown mismatch");
    deactivate_eq_a: assert property (@(posedge clock) // [R9]
        disable iff (rst) path_deactivate_signal == (path_reteardown_signal
        || |(lane_tx_output_disable_bit_r & media_mask)
        || |(lane_tx_squelch_force_bit_r & media_mask)))
        else $error("deactivate mismatch");
    sig_read_a: assert property (@(posedge clock) // [R9]
        disable iff (rst) reg_rd && reg_addr == `DTS_OFF_SIG
        |=> reg_rdata == {29'h0, $past(path_deactivate_signal),
        $past(path_reteardown_signal), $past(path_teardown_signal)})
        else $error("signal read mismatch");
    tx_terms_a: assert property (@(posedge clock) // [R10]
        disable iff (rst)
        path_tx_disable_term == |(lane_tx_output_disable_bit_r & media_mask)
        && path_tx_force_squelch_term
        == |(lane_tx_squelch_force_bit_r & media_mask))
        else $error("tx term mismatch");
    lane_off_a: assert property (@(posedge clock) // [R11]
        disable iff (rst)
        |((lane_tx_output_disable_bit_r | lane_tx_squelch_force_bit_r)
        & media_mask) |-> path_deactivate_signal)
        else $error("lane off ignored");
    deinit_wr_a: assert property (@(posedge clock) // [R12]
        disable iff (rst) reg_wr && reg_addr == `DTS_OFF_DEINIT
        |=> lane_deinit_request_bit_r == $past(wr_lanes))
        else $error("deinit write lost");
    rdata_idle_a: assert property (@(posedge clock) // [R12]
        disable iff (rst) !$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not idle");
    mask_low_a: assert property (@(posedge clock) // [R13]
        disable iff (rst) (host_mask
        & ((LANES'(1) << first_lane_r) - LANES'(1))) == '0)
        else $error("lane below first selected");
    mask_high_a: assert property (@(posedge clock) // [R13]
        disable iff (rst)
        ((host_mask >> first_lane_r) >> lane_count_r) == '0)
        else $error("lane beyond count selected");
endmodule

/* inc/dts_defs.svh */
// Purpose: constants for the data path transition signal block
// Assumes: included by its bare name
// Notes: register offsets are word indices on the plain register port
`ifndef DTS_DEFS_SVH
`define DTS_DEFS_SVH

`define DTS_LANES 8
`define DTS_ADDR_W 4
`define DTS_OFF_DEINIT 4'h0
`define DTS_OFF_TXDIS 4'h1
`define DTS_OFF_SQF 4'h2
`define DTS_OFF_CFG 4'h3
`define DTS_OFF_APPLY 4'h4
`define DTS_OFF_PEND 4'h5
`define DTS_OFF_SIG 4'h6
`define DTS_OFF_STATE 4'h7
`define DTS_APPLY_INIT_BIT 8
`define DTS_APPLY_IMM_BIT 9
`define DTS_CFG_STEPPED_BIT 0
`define DTS_CFG_FIRST_LSB 4
`define DTS_CFG_COUNT_LSB 8
`define DTS_DEINIT_RST 8'hff
`define DTS_CFG_RST 32'h0000_0800

`endif

/* inc/dts_pkg.sv */
// Purpose: types for the data path transition signal block
// Assumes: nothing
// Notes: state codes follow declaration order, 0 to 6
package dts_pkg;
    typedef enum logic [2:0] {
        DTS_DEACTIVATED,
        DTS_INITIALISING,
        DTS_DEINIT,
        DTS_INITIALISED,
        DTS_TX_TURNING_ON,
        DTS_ACTIVATED,
        DTS_TX_TURNING_OFF
    } dts_path_state_t;
endpackage

/* testbench/dts_host.sv */
// Purpose: host model driving the plain register port
// Assumes: one clock, strobes one cycle long, no wait states
// Notes: read data taken in the cycle after the read strobe
`timescale 1ns/1ps
`include "dts_defs.svh"

module dts_host (
    input wire logic clock,
    output logic [`DTS_ADDR_W-1:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // released data lines show the inverse of the last value
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

/* testbench/testbench.sv */
// Purpose: self-checking bench of the transition signal block
// Assumes: host model drives the register port
// Notes: signals packed as {deactivate, reteardown, teardown}
`timescale 1ns/1ps
`include "dts_defs.svh"

module testbench;
    import dts_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    logic reg_wr, reg_rd, copy_done, tear, retear, deact;
    logic module_ready_state = 1'b1;
    logic low_power_signal = 1'b0;
    dts_path_state_t path_state = DTS_DEACTIVATED;
    int n_errors = 0;
    int num_checks = 0;

    initial copy_done = 1'b0;
    initial forever #25 clock = ~clock;

    dts_host i_host (.clock(clock), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    dts_transition i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .module_ready_state(module_ready_state),
        .low_power_signal(low_power_signal), .path_state(path_state),
        .copy_done(copy_done), .path_teardown_signal(tear),
        .path_reteardown_signal(retear), .path_deactivate_signal(deact));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] exp_v, input logic [31:0] got_v);
        num_checks++;
        if (got_v !== exp_v) begin
            n_errors++;
            $display("wrong value at %0t: expected %h got %h",
                $time, exp_v, got_v);
        end
    endtask

    function automatic logic [31:0] sigs();
        return {29'h0, deact, retear, tear};
    endfunction

    task automatic pulse_copy();
        @(posedge clock);
        copy_done <= 1'b1;
        @(posedge clock);
        copy_done <= 1'b0;
        #1;
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        i_host.rd(`DTS_OFF_DEINIT, rv);
        chk(32'h0000_00ff, rv);
        i_host.rd(`DTS_OFF_CFG, rv);
        chk(32'h0000_0800, rv);
        i_host.rd(`DTS_OFF_PEND, rv);
        chk(32'h0, rv);
        i_host.rd(4'hf, rv);
        chk(32'h0, rv);
        i_host.rd(`DTS_OFF_SIG, rv);
        chk(32'h7, rv);
    endtask

    task automatic t_teardown();
        i_host.wr(`DTS_OFF_CFG, 32'h0000_0200);
        i_host.wr(`DTS_OFF_DEINIT, 32'h0);
        chk(32'h0, sigs());
        i_host.wr(`DTS_OFF_DEINIT, 32'h4);
        chk(32'h0, sigs());
        i_host.wr(`DTS_OFF_DEINIT, 32'h2);
        chk(32'h7, sigs());
        i_host.wr(`DTS_OFF_DEINIT, 32'h0);
        @(posedge clock);
        low_power_signal <= 1'b1;
        #1;
        chk(32'h7, sigs());
        @(posedge clock);
        low_power_signal <= 1'b0;
        module_ready_state <= 1'b0;
        #1;
        chk(32'h7, sigs());
        @(posedge clock);
        module_ready_state <= 1'b1;
        #1;
    endtask

    task automatic t_apply();
        i_host.wr(`DTS_OFF_APPLY, 32'h0000_0201);
        pulse_copy();
        i_host.rd(`DTS_OFF_PEND, rv);
        chk(32'h0, rv);
        i_host.wr(`DTS_OFF_APPLY, 32'h0000_0106);
        pulse_copy();
        i_host.rd(`DTS_OFF_PEND, rv);
        chk(32'h6, rv);
        chk(32'h6, sigs());
        i_host.wr(`DTS_OFF_CFG, 32'h0000_0201);
        chk(32'h0, sigs());
        i_host.wr(`DTS_OFF_CFG, 32'h0000_0200);
        @(posedge clock);
        path_state <= DTS_INITIALISING;
        @(posedge clock);
        path_state <= DTS_ACTIVATED;
        i_host.rd(`DTS_OFF_PEND, rv);
        chk(32'h4, rv);
        chk(32'h0, sigs());
        // re-arm replaces lanes; copy during init keeps them
        i_host.wr(`DTS_OFF_APPLY, 32'h0000_0101);
        i_host.wr(`DTS_OFF_APPLY, 32'h0000_0102);
        @(posedge clock);
        path_state <= DTS_INITIALISING;
        copy_done <= 1'b1;
        @(posedge clock);
        path_state <= DTS_ACTIVATED;
        copy_done <= 1'b0;
        i_host.rd(`DTS_OFF_PEND, rv);
        chk(32'h6, rv);
        @(posedge clock);
        path_state <= DTS_INITIALISING;
        @(posedge clock);
        path_state <= DTS_ACTIVATED;
        #1;
        chk(32'h0, sigs());
    endtask

    task automatic t_deact();
        i_host.wr(`DTS_OFF_TXDIS, 32'h20);
        chk(32'h0, sigs());
        i_host.wr(`DTS_OFF_TXDIS, 32'h01);
        chk(32'h4, sigs());
        i_host.wr(`DTS_OFF_TXDIS, 32'h0);
        i_host.wr(`DTS_OFF_SQF, 32'h02);
        chk(32'h4, sigs());
        i_host.wr(`DTS_OFF_SQF, 32'h0);
        chk(32'h0, sigs());
        i_host.rd(`DTS_OFF_STATE, rv);
        chk(32'(DTS_ACTIVATED), rv);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_teardown();
        t_apply();
        t_deact();
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        give_verdict();
    end
endmodule
